//--- design/atic_cmd_if.sv
// Purpose: Carries one decoded command, or one reply request, between the decoder's modules.
// Assumes: Valid stays high with stable fields until ready is seen high.
// Notes: On the reply path the typ field carries the status code.
`timescale 1ns/10ps
interface atic_cmd_if;
  logic valid;
  logic ready;
  logic [7:0] code;
  logic [7:0] typ;
  logic [7:0] bank;
  logic [31:0] value;
  modport src (output valid, output code, output typ, output bank, output value, input ready);
  modport dst (input valid, input code, input typ, input bank, input value, output ready);
endinterface

//--- design/atic_frame_rx.sv
// Purpose: Gathers nine command bytes into one command and offers it downstream.
// Assumes: Bytes come from a receiver on pclk; checksum is not checked here.
// Notes: Frames for another module address are dropped silently.
`timescale 1ns/10ps
module atic_frame_rx #(
  parameter logic [7:0] MOD_ADDR = 8'h01
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  atic_cmd_if.src cmd
);
  import atic_pkg::*;
  logic [3:0] cnt_reg;
  logic [7:0] buf_reg [FRAME_LEN];
  logic full_reg;

  // A held command blocks further bytes so back-pressure reaches the sender.
  assign byte_ready = !full_reg;
  assign cmd.valid = full_reg;
  assign cmd.code = buf_reg[1];
  assign cmd.typ = buf_reg[2];
  assign cmd.bank = buf_reg[3];
  assign cmd.value = {buf_reg[4], buf_reg[5], buf_reg[6], buf_reg[7]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      full_reg <= 1'b0;
    end else if (full_reg) begin
      if (cmd.ready) begin
        full_reg <= 1'b0;
      end
    end else if (byte_valid) begin
      if (cnt_reg == LAST_BYTE) begin
        cnt_reg <= 4'h0;
        full_reg <= (buf_reg[0] == MOD_ADDR);
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FRAME_LEN; i++) begin
        buf_reg[i] <= 8'h00;
      end
    end else if (byte_valid && !full_reg) begin
      buf_reg[cnt_reg] <= byte_data;
    end
  end
endmodule

//--- design/atic_pkg.sv
// Purpose: Shared constants for the accumulator, error-flag and interrupt command decoder.
// Assumes: Nine-byte frames, 32-bit APB data, one register per aligned word.
// Notes: The error-flag selection decode lives here because the core and its checks both use it.
package atic_pkg;
  localparam logic [7:0] OP_ACCU_AXIS = 8'h22;
  localparam logic [7:0] OP_ACCU_GLOB = 8'h23;
  localparam logic [7:0] OP_ERR_CLR = 8'h24;
  localparam logic [7:0] OP_IRQ_EN = 8'h19;
  localparam logic [7:0] OP_IRQ_MASK = 8'h1A;
  localparam logic [7:0] OP_IRQ_ENTRY = 8'h25;
  localparam logic [7:0] OP_IRQ_RET = 8'h26;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] HOST_ADDR = 8'h02;
  localparam logic [7:0] USER_BANK = 8'h02;
  localparam logic [7:0] IRQ_GLOBAL = 8'hFF;
  localparam logic [7:0] SEL_ALL = 8'h00;
  localparam logic [7:0] SEL_TIMEOUT = 8'h01;
  localparam logic [7:0] SEL_ALARM = 8'h02;
  localparam logic [7:0] SEL_DEVIATION = 8'h03;
  localparam logic [7:0] SEL_POSITION = 8'h04;
  localparam logic [7:0] SEL_SHUTDOWN = 8'h05;
  localparam int ERR_N = 5;
  localparam int IRQ_N = 16;
  localparam int IRQ_W = 4;
  localparam int UVAR_N = 64;
  localparam int UVAR_W = 6;
  localparam int PC_W = 16;
  localparam int FRAME_LEN = 9;
  localparam logic [3:0] LAST_BYTE = 4'h8;
  localparam logic [11:0] A_ACCU = 12'h000;
  localparam logic [11:0] A_XREG = 12'h004;
  localparam logic [11:0] A_ERR = 12'h008;
  localparam logic [11:0] A_IRQ_EN = 12'h00C;
  localparam logic [11:0] A_UVAR_SEL = 12'h010;
  localparam logic [11:0] A_UVAR_DATA = 12'h014;
  localparam logic [11:0] A_VEC_SEL = 12'h018;
  localparam logic [11:0] A_VEC_DATA = 12'h01C;
  localparam logic [11:0] A_IRQ_STAT = 12'h020;
  localparam int GLOBAL_EN_BIT = 31;
  localparam int VEC_VALID_BIT = 16;

  typedef enum logic {RPL_IDLE, RPL_SEND} atic_rpl_e;

  function automatic logic [ERR_N-1:0] atic_err_mask(input logic [7:0] sel);
    logic [ERR_N-1:0] m;
    m = 5'h00;
    unique case (sel)
      SEL_ALL: m = 5'h1F;
      SEL_TIMEOUT: m = 5'h01;
      SEL_ALARM: m = 5'h02;
      SEL_DEVIATION: m = 5'h04;
      SEL_POSITION: m = 5'h08;
      SEL_SHUTDOWN: m = 5'h10;
      default: m = 5'h00;
    endcase
    return m;
  endfunction
endpackage

//--- design/atic_reply_tx.sv
// Purpose: Sends the nine-byte direct-mode reply for one executed command.
// Assumes: The checksum is the byte sum of the first eight reply bytes.
// Notes: Bytes leave through a shift register so the byte output is a flop.
`timescale 1ns/10ps
module atic_reply_tx #(
  parameter logic [7:0] MOD_ADDR = 8'h01
) (
  input wire logic pclk,
  input wire logic presetn,
  atic_cmd_if.dst rq,
  output logic rpl_valid,
  output logic [7:0] rpl_byte,
  input wire logic rpl_ready
);
  import atic_pkg::*;
  atic_rpl_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg [FRAME_LEN];
  logic [7:0] sum;

  assign rq.ready = (state_reg == RPL_IDLE);
  assign rpl_valid = (state_reg == RPL_SEND);
  assign rpl_byte = sh_reg[0];
  assign sum = HOST_ADDR + MOD_ADDR + rq.typ + rq.code + rq.value[31:24] + rq.value[23:16]
               + rq.value[15:8] + rq.value[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RPL_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        RPL_IDLE: begin
          if (rq.valid) begin
            state_reg <= RPL_SEND;
            cnt_reg <= 4'h0;
          end
        end
        RPL_SEND: begin
          if (rpl_ready) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == LAST_BYTE) begin
              state_reg <= RPL_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FRAME_LEN; i++) begin
        sh_reg[i] <= 8'h00;
      end
    end else if (rq.valid && rq.ready) begin
      sh_reg <= '{HOST_ADDR, MOD_ADDR, rq.typ, rq.code, rq.value[31:24], rq.value[23:16],
                  rq.value[15:8], rq.value[7:0], sum};
    end else if (rpl_valid && rpl_ready) begin
      for (int i = 0; i < FRAME_LEN - 1; i++) begin
        sh_reg[i] <= sh_reg[i+1];
      end
      sh_reg[FRAME_LEN-1] <= 8'h00;
    end
  end
endmodule

//--- design/atic_top.sv
// Purpose: Executes the accumulator transfer, error-flag clear and interrupt commands.
// Assumes: Direct frames and program instructions both arrive on pclk; raise and request pins are asynchronous.
// Notes: One command executes per cycle; a direct frame wins over a program instruction.
`timescale 1ns/10ps
module atic_top #(
  parameter logic [7:0] MOD_ADDR = 8'h01
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frm_valid,
  input wire logic [7:0] frm_byte,
  output logic frm_ready,
  input wire logic prog_valid,
  input wire logic [7:0] prog_code,
  input wire logic [7:0] prog_typ,
  input wire logic [7:0] prog_bank,
  input wire logic [31:0] prog_value,
  input wire logic [atic_pkg::PC_W-1:0] prog_pc,
  output logic prog_ready,
  input wire logic [atic_pkg::ERR_N-1:0] err_raise,
  input wire logic [atic_pkg::IRQ_N-1:0] irq_req,
  output logic axis_wr,
  output logic [7:0] axis_num,
  output logic [7:0] axis_motor,
  output logic [31:0] axis_data,
  output logic glob_wr,
  output logic [7:0] glob_bank,
  output logic [7:0] glob_idx,
  output logic [31:0] glob_data,
  output logic irq_take,
  output logic [atic_pkg::IRQ_W-1:0] irq_num,
  output logic [atic_pkg::PC_W-1:0] irq_pc,
  output logic ret_valid,
  output logic [atic_pkg::PC_W-1:0] ret_pc,
  output logic [atic_pkg::ERR_N-1:0] err_flags,
  output logic rpl_valid,
  output logic [7:0] rpl_byte,
  input wire logic rpl_ready
);
  import atic_pkg::*;
  atic_cmd_if cmd ();
  atic_cmd_if rq ();

  logic [ERR_N-1:0] raise_s1, raise_s2, raise_s3;
  logic [IRQ_N-1:0] req_s1, req_s2, req_s3;
  logic [31:0] accu_reg, x_reg, sv_accu_reg, sv_x_reg;
  logic [ERR_N-1:0] err_reg, sv_err_reg;
  logic [PC_W-1:0] sv_pc_reg;
  logic [IRQ_N-1:0] en_reg, pend_reg, vvalid_reg;
  logic [PC_W-1:0] vec_reg [IRQ_N];
  logic glob_en_reg, in_irq_reg;
  logic [31:0] uvar_reg [UVAR_N];
  logic [UVAR_W-1:0] usel_reg;
  logic [IRQ_W-1:0] vsel_reg;
  logic rq_valid_reg;
  logic [7:0] rq_code_reg, rq_st_reg;
  logic dir_fire, ex_fire, known, ret_fire, take;
  logic [7:0] ex_code, ex_typ, ex_bank;
  logic [31:0] ex_value;
  logic [ERR_N-1:0] raise_ev, clr_mask;
  logic [IRQ_N-1:0] ready_irq;
  logic [IRQ_W-1:0] take_idx;
  logic apb_wr, apb_rd, hit;

  atic_frame_rx #(.MOD_ADDR(MOD_ADDR)) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .byte_valid(frm_valid),
    .byte_data(frm_byte),
    .byte_ready(frm_ready),
    .cmd(cmd.src)
  );

  atic_reply_tx #(.MOD_ADDR(MOD_ADDR)) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .rq(rq.dst),
    .rpl_valid(rpl_valid),
    .rpl_byte(rpl_byte),
    .rpl_ready(rpl_ready)
  );

  // Pins are asynchronous; a third stage gives edge detection without touching stage one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raise_s1 <= 5'h00;
      raise_s2 <= 5'h00;
      raise_s3 <= 5'h00;
      req_s1 <= 16'h0000;
      req_s2 <= 16'h0000;
      req_s3 <= 16'h0000;
    end else begin
      raise_s1 <= err_raise;
      raise_s2 <= raise_s1;
      raise_s3 <= raise_s2;
      req_s1 <= irq_req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end
  assign raise_ev = raise_s2 & ~raise_s3;

  // A direct command waits until the previous reply has been handed to the sender.
  assign cmd.ready = !rq_valid_reg;
  assign dir_fire = cmd.valid && cmd.ready;
  assign prog_ready = !dir_fire;
  assign ex_fire = dir_fire || prog_valid;
  assign ex_code = dir_fire ? cmd.code : prog_code;
  assign ex_typ = dir_fire ? cmd.typ : prog_typ;
  assign ex_bank = dir_fire ? cmd.bank : prog_bank;
  assign ex_value = dir_fire ? cmd.value : prog_value;
  assign known = ex_code inside {OP_ACCU_AXIS, OP_ACCU_GLOB, OP_ERR_CLR, OP_IRQ_EN, OP_IRQ_MASK,
                                 OP_IRQ_ENTRY, OP_IRQ_RET};
  assign ret_fire = ex_fire && ex_code == OP_IRQ_RET && in_irq_reg;
  assign clr_mask = (ex_fire && ex_code == OP_ERR_CLR) ? atic_err_mask(ex_typ) : 5'h00;

  // Copies to parameters leave the block as one-cycle write strobes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_wr <= 1'b0;
      glob_wr <= 1'b0;
      axis_num <= 8'h00;
      axis_motor <= 8'h00;
      axis_data <= 32'h0000_0000;
      glob_bank <= 8'h00;
      glob_idx <= 8'h00;
      glob_data <= 32'h0000_0000;
    end else begin
      axis_wr <= ex_fire && ex_code == OP_ACCU_AXIS;
      glob_wr <= ex_fire && ex_code == OP_ACCU_GLOB;
      if (ex_fire && ex_code == OP_ACCU_AXIS) begin
        axis_num <= ex_typ;
        axis_motor <= ex_bank;
        axis_data <= accu_reg;
      end
      if (ex_fire && ex_code == OP_ACCU_GLOB) begin
        glob_idx <= ex_typ;
        glob_bank <= ex_bank;
        glob_data <= accu_reg;
      end
    end
  end

  // User variables above the stored range are passed out on the global write only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < UVAR_N; i++) begin
        uvar_reg[i] <= 32'h0000_0000;
      end
    end else if (ex_fire && ex_code == OP_ACCU_GLOB && ex_bank == USER_BANK && ex_typ < 8'(UVAR_N)) begin
      uvar_reg[ex_typ[UVAR_W-1:0]] <= accu_reg;
    end
  end

  // A restore wins over a software load of the accumulator in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accu_reg <= 32'h0000_0000;
      x_reg <= 32'h0000_0000;
    end else if (ret_fire) begin
      accu_reg <= sv_accu_reg;
      x_reg <= sv_x_reg;
    end else if (apb_wr && paddr == A_ACCU) begin
      accu_reg <= pwdata;
    end else if (apb_wr && paddr == A_XREG) begin
      x_reg <= pwdata;
    end
  end

  // A raise in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 5'h00;
    end else if (ret_fire) begin
      err_reg <= sv_err_reg | raise_ev;
    end else begin
      err_reg <= (err_reg & ~clr_mask) | raise_ev;
    end
  end
  assign err_flags = err_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 16'h0000;
      glob_en_reg <= 1'b0;
    end else if (ex_fire && ex_code == OP_IRQ_EN) begin
      if (ex_typ == IRQ_GLOBAL) begin
        glob_en_reg <= 1'b1;
      end else if (ex_typ < 8'(IRQ_N)) begin
        en_reg[ex_typ[IRQ_W-1:0]] <= 1'b1;
      end
    end else if (ex_fire && ex_code == OP_IRQ_MASK) begin
      if (ex_typ == IRQ_GLOBAL) begin
        glob_en_reg <= 1'b0;
      end else if (ex_typ < 8'(IRQ_N)) begin
        en_reg[ex_typ[IRQ_W-1:0]] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vvalid_reg <= 16'h0000;
      for (int i = 0; i < IRQ_N; i++) begin
        vec_reg[i] <= 16'h0000;
      end
    end else if (ex_fire && ex_code == OP_IRQ_ENTRY && ex_typ < 8'(IRQ_N)) begin
      vec_reg[ex_typ[IRQ_W-1:0]] <= ex_value[PC_W-1:0];
      vvalid_reg[ex_typ[IRQ_W-1:0]] <= 1'b1;
    end
  end

  // Requests are remembered on their rising edge; the lowest ready number is served first.
  assign ready_irq = pend_reg & en_reg & vvalid_reg & {IRQ_N{glob_en_reg}};
  always_comb begin
    take_idx = 4'h0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (ready_irq[i]) begin
        take_idx = IRQ_W'(i);
      end
    end
  end
  assign take = |ready_irq && !in_irq_reg && !ex_fire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 16'h0000;
      in_irq_reg <= 1'b0;
      irq_take <= 1'b0;
      irq_num <= 4'h0;
      irq_pc <= 16'h0000;
      ret_valid <= 1'b0;
      ret_pc <= 16'h0000;
    end else begin
      pend_reg <= (pend_reg & ~(take ? (16'h0001 << take_idx) : 16'h0000)) | (req_s2 & ~req_s3);
      irq_take <= take;
      ret_valid <= ret_fire;
      if (take) begin
        in_irq_reg <= 1'b1;
        irq_num <= take_idx;
        irq_pc <= vec_reg[take_idx];
      end else if (ret_fire) begin
        in_irq_reg <= 1'b0;
        ret_pc <= sv_pc_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sv_accu_reg <= 32'h0000_0000;
      sv_x_reg <= 32'h0000_0000;
      sv_err_reg <= 5'h00;
      sv_pc_reg <= 16'h0000;
    end else if (take) begin
      sv_accu_reg <= accu_reg;
      sv_x_reg <= x_reg;
      sv_err_reg <= err_reg;
      sv_pc_reg <= prog_pc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq_valid_reg <= 1'b0;
      rq_code_reg <= 8'h00;
      rq_st_reg <= 8'h00;
    end else if (dir_fire) begin
      rq_valid_reg <= 1'b1;
      rq_code_reg <= cmd.code;
      rq_st_reg <= known ? ST_OK : ST_BAD_CMD;
    end else if (rq.ready) begin
      rq_valid_reg <= 1'b0;
    end
  end
  assign rq.valid = rq_valid_reg;
  assign rq.code = rq_code_reg;
  assign rq.typ = rq_st_reg;
  assign rq.bank = 8'h00;
  assign rq.value = 32'h0000_0000;

  // APB answers in the access cycle with no wait states.
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign hit = paddr inside {A_ACCU, A_XREG, A_ERR, A_IRQ_EN, A_UVAR_SEL, A_UVAR_DATA, A_VEC_SEL,
                             A_VEC_DATA, A_IRQ_STAT};
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usel_reg <= 6'h00;
      vsel_reg <= 4'h0;
    end else if (apb_wr && paddr == A_UVAR_SEL) begin
      usel_reg <= pwdata[UVAR_W-1:0];
    end else if (apb_wr && paddr == A_VEC_SEL) begin
      vsel_reg <= pwdata[IRQ_W-1:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      unique case (paddr)
        A_ACCU: prdata = accu_reg;
        A_XREG: prdata = x_reg;
        A_ERR: prdata = {27'h0, err_reg};
        A_IRQ_EN: prdata = {glob_en_reg, 15'h0, en_reg};
        A_UVAR_SEL: prdata = {26'h0, usel_reg};
        A_UVAR_DATA: prdata = uvar_reg[usel_reg];
        A_VEC_SEL: prdata = {28'h0, vsel_reg};
        A_VEC_DATA: prdata = {15'h0, vvalid_reg[vsel_reg], vec_reg[vsel_reg]};
        A_IRQ_STAT: prdata = {in_irq_reg, 15'h0, pend_reg};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_axis_cmd;
    ex_fire && ex_code == OP_ACCU_AXIS;
  endsequence
  sequence s_direct_known;
    dir_fire && known;
  endsequence

  a_axis_copy: assert property (s_axis_cmd |=> axis_wr && axis_data == $past(accu_reg)
    && axis_num == $past(ex_typ)) else $error("axis copy wrong");
  a_glob_copy: assert property (ex_fire && ex_code == OP_ACCU_GLOB |=> glob_wr
    && glob_data == $past(accu_reg) && glob_bank == $past(ex_bank)) else $error("global copy wrong");
  a_user_var: assert property (ex_fire && ex_code == OP_ACCU_GLOB && ex_bank == USER_BANK
    && ex_typ < 8'(UVAR_N) |=> uvar_reg[$past(ex_typ[UVAR_W-1:0])] == $past(accu_reg))
    else $error("user variable not written");
  a_err_clear: assert property (|clr_mask && !ret_fire && raise_ev == 5'h00
    |=> (err_reg & $past(clr_mask)) == 5'h00) else $error("flag not cleared");
  a_err_keep: assert property (!ret_fire && raise_ev == 5'h00
    |=> (err_reg & ~$past(clr_mask)) == ($past(err_reg) & ~$past(clr_mask))) else $error("flag changed");
  a_glob_on: assert property (ex_fire && ex_code == OP_IRQ_EN && ex_typ == IRQ_GLOBAL
    |=> glob_en_reg && $stable(en_reg)) else $error("global enable missed");
  a_glob_off: assert property (ex_fire && ex_code == OP_IRQ_MASK && ex_typ == IRQ_GLOBAL
    |=> !glob_en_reg && $stable(en_reg)) else $error("global disable wrong");
  a_vec_store: assert property (ex_fire && ex_code == OP_IRQ_ENTRY && ex_typ < 8'(IRQ_N)
    |=> vec_reg[$past(ex_typ[IRQ_W-1:0])] == $past(ex_value[PC_W-1:0])) else $error("vector not stored");
  // The served number only shows after the take edge, so the gates are looked up with today's irq_num.
  a_take_gate: assert property (irq_take |-> $past(glob_en_reg)
    && (($past(en_reg & vvalid_reg & pend_reg) >> irq_num) & 16'h0001) == 16'h0001)
    else $error("interrupt taken while gated");
  a_reply_ok: assert property (s_direct_known |=> rq_valid_reg && rq_st_reg == ST_OK
    ##[0:20] rq.ready) else $error("no OK reply");
  a_restore: assert property (ret_fire |=> accu_reg == $past(sv_accu_reg) && ret_valid
    && ret_pc == $past(sv_pc_reg) && !in_irq_reg) else $error("return restore wrong");
endmodule

//--- testbench/atic_host.sv
// Purpose: Host side of the command link: sends frames and drains replies.
// Assumes: Frames go to module address 01h; reply bytes are taken slowly.
// Notes: A released byte line shows the inverse of the last byte.
`timescale 1ns/10ps
module atic_host (
  input wire logic pclk,
  output logic frm_valid,
  output logic [7:0] frm_byte,
  input wire logic frm_ready,
  output logic rpl_ready
);
  initial begin
    frm_valid = 1'b0;
    frm_byte = 8'h00;
    rpl_ready = 1'b0;
  end
  // Stalling every other cycle makes the reply path hold each byte.
  always @(posedge pclk) rpl_ready <= ~rpl_ready;
  task automatic send(input logic [7:0] c, t, b, input logic [31:0] v);
    logic [7:0] f [9];
    f = '{8'h01, c, t, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    for (int i = 0; i < 9; i++) begin
      {frm_valid, frm_byte} <= {1'b1, f[i]};
      @(posedge pclk iff frm_ready === 1'b1);
    end
    {frm_valid, frm_byte} <= {1'b0, ~f[8]};
  endtask
endmodule

//--- testbench/tb.sv
// Purpose: Self-checking bench for the command decoder.
// Assumes: Zero-wait APB; pin raises show within five cycles.
// Notes: Event outputs are matched against a queue of expected notes.
`timescale 1ns/10ps
module tb;
  import atic_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frm_valid, frm_ready, prog_valid, prog_ready;
  logic axis_wr, glob_wr, irq_take, ret_valid, rpl_valid, rpl_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prog_value, axis_data, glob_data, rnd;
  logic [7:0] frm_byte, prog_code, prog_typ, prog_bank, axis_num, axis_motor, glob_bank, glob_idx, rpl_byte;
  logic [15:0] prog_pc, irq_pc, ret_pc, irq_req;
  logic [4:0] err_raise, err_flags;
  logic [3:0] irq_num;
  logic [7:0] st_exp;
  logic [47:0] exp_q [$];
  int err_total, tests_run, rb;
  atic_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .frm_valid, .frm_byte, .frm_ready, .prog_valid, .prog_code, .prog_typ, .prog_bank, .prog_value,
    .prog_pc, .prog_ready, .err_raise, .irq_req, .axis_wr, .axis_num, .axis_motor, .axis_data, .glob_wr,
    .glob_bank, .glob_idx, .glob_data, .irq_take, .irq_num, .irq_pc, .ret_valid, .ret_pc, .err_flags,
    .rpl_valid, .rpl_byte, .rpl_ready);
  atic_host host (.pclk, .frm_valid, .frm_byte, .frm_ready, .rpl_ready);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, x, input logic xe);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready === 1'b1);
    if (!w) chk("prdata", 48'(x), 48'(prdata));
    chk("pslverr", 48'(xe), 48'(pslverr));
    {psel, penable, pwdata} <= {2'b00, ~d};
    @(posedge pclk);
  endtask
  task automatic prog(input logic [7:0] c, t, b, input logic [31:0] v);
    {prog_valid, prog_code, prog_typ, prog_bank, prog_value} <= {1'b1, c, t, b, v};
    @(posedge pclk iff prog_ready === 1'b1);
    {prog_valid, prog_code, prog_typ, prog_bank, prog_value} <= {1'b0, ~c, ~t, ~b, ~v};
    @(posedge pclk);
  endtask
  task automatic wait_rpl();
    @(posedge pclk iff rpl_valid === 1'b1);
    @(posedge pclk iff rpl_valid === 1'b0);
  endtask
  task automatic raise_all();
    err_raise <= 5'h1F;
    repeat (5) @(posedge pclk);
    err_raise <= 5'h00;
  endtask
  always @(posedge pclk) begin
    if (axis_wr === 1'b1) chk("axis", exp_q.pop_front(), {axis_num, axis_motor, axis_data});
    if (glob_wr === 1'b1) chk("glob", exp_q.pop_front(), {glob_idx, glob_bank, glob_data});
    if (irq_take === 1'b1) chk("irq", exp_q.pop_front(), {4'h0, irq_num, 24'h0, irq_pc});
    if (ret_valid === 1'b1) chk("ret", exp_q.pop_front(), {32'h0, ret_pc});
    if (rpl_valid === 1'b1 && rpl_ready === 1'b1) begin
      if (rb == 2) chk("status", {40'h0, st_exp}, {40'h0, rpl_byte});
      rb = (rb == 8) ? 0 : rb + 1;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // The whole sequence needs well under 2000 cycles; this bound is ten times that.
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, prog_valid, prog_code, prog_typ, prog_bank, prog_value} = '0;
    {prog_pc, err_raise, irq_req, presetn, rb} = {16'h0040, 21'h0, 1'b0, 32'h0};
    rnd = lfsr(32'hD5E65528);
    st_exp = ST_OK;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, A_ACCU, rnd, 32'h0, 1'b0);
    apb(1'b0, A_ACCU, 32'h0, rnd, 1'b0);
    apb(1'b0, 12'h0FC, 32'h0, 32'h0, 1'b1);
    exp_q.push_back({8'h05, 8'h00, rnd});
    host.send(OP_ACCU_AXIS, 8'h05, 8'h00, ~rnd);
    wait_rpl();
    exp_q.push_back({8'h2A, USER_BANK, rnd});
    prog(OP_ACCU_GLOB, 8'h2A, USER_BANK, ~rnd);
    apb(1'b1, A_UVAR_SEL, 32'h0000002A, 32'h0, 1'b0);
    apb(1'b0, A_UVAR_DATA, 32'h0, rnd, 1'b0);
    raise_all();
    for (int s = 1; s <= 5; s++) begin
      prog(OP_ERR_CLR, 8'(s), rnd[7:0], rnd);
      repeat (2) @(posedge pclk);
      // The shift is cut to five bits first, since the wide cast would keep the bits shifted out.
      chk("flags", 48'(5'(5'h1F << s)), 48'(err_flags));
    end
    raise_all();
    host.send(OP_ERR_CLR, SEL_ALL, 8'h00, 32'h0);
    wait_rpl();
    chk("flags", 48'h0, 48'(err_flags));
    st_exp = ST_BAD_CMD;
    host.send(8'h00, 8'h00, 8'h00, 32'h0);
    wait_rpl();
    st_exp = ST_OK;
    prog(OP_IRQ_EN, 8'h03, 8'h00, 32'h0);
    prog(OP_IRQ_ENTRY, 8'h03, 8'h00, 32'h50);
    prog(OP_IRQ_ENTRY, 8'h03, 8'h00, 32'h77);
    irq_req <= 16'h0008;
    repeat (8) @(posedge pclk);
    exp_q.push_back({8'h03, 24'h0, 16'h0077});
    prog(OP_IRQ_EN, IRQ_GLOBAL, 8'h00, 32'h0);
    apb(1'b0, A_IRQ_EN, 32'h0, 32'h80000008, 1'b0);
    apb(1'b1, A_ACCU, ~rnd, 32'h0, 1'b0);
    exp_q.push_back({32'h0, prog_pc});
    prog(OP_IRQ_RET, IRQ_GLOBAL, 8'h00, 32'h0);
    repeat (2) @(posedge pclk);
    apb(1'b0, A_ACCU, 32'h0, rnd, 1'b0);
    host.send(OP_IRQ_MASK, IRQ_GLOBAL, 8'h00, 32'h0);
    wait_rpl();
    apb(1'b0, A_IRQ_EN, 32'h0, 32'h00000008, 1'b0);
    prog(OP_IRQ_MASK, 8'h03, 8'h00, 32'h0);
    apb(1'b0, A_IRQ_EN, 32'h0, 32'h0, 1'b0);
    wrap_up();
  end
endmodule
